// ---- tsf_pkg.sv ----
`default_nettype none
package tsf_pkg;
  // ************************************************************
  // register offsets within one link
  // ************************************************************
  localparam logic [7:0] OFF_TEST_CFG = 8'hc7;
  localparam logic [7:0] OFF_ACC_STAT = 8'hc8;
  localparam logic [7:0] OFF_ACC_CTRL = 8'hc9;
  localparam logic [7:0] OFF_ACC_DATA = 8'hca;
  localparam logic [7:0] OFF_PAY_CFG = 8'hcb;
  localparam logic [7:0] OFF_PAY_EN = 8'hcc;
  localparam logic [7:0] OFF_FGEN_MODE = 8'hd0;
  localparam logic [7:0] OFF_ERR_INS = 8'hd1;
  localparam int LINK_ADDR_LSB = 8;
  localparam int REG_ADDR_W = 11;
  // indirect table bases
  localparam logic [6:0] IND_CHAN_BASE = 7'h01;
  localparam logic [6:0] IND_DTRK_BASE = 7'h21;
  localparam logic [6:0] IND_STRK_BASE = 7'h41;
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int PEN_MASTER = 0;
  localparam int PEN_NIBSEL = 1;
  localparam int PCF_FREEZE = 0;
  localparam int PCF_GLOBAL = 1;
  localparam int STRK_EN = 4;
  localparam int CTRL_RNW = 7;
  localparam int STAT_BUSY = 0;
  localparam int FM_ESF = 0;
  localparam int FM_J1 = 1;
  localparam int FM_FRAMING_DISABLE = 2;
  localparam int FM_CRC_INSERT_BYPASS = 3;
  localparam int FM_DLBYP = 4;
  localparam int FM_COPYF = 5;
  localparam int FM_MANYEL = 6;
  localparam int FM_AUTOYEL = 7;
  localparam int EI_FT = 0;
  localparam int EI_FS = 1;
  localparam int EI_CRC = 2;
  localparam int DL_BOC = 2;
  localparam int DL_PRM = 1;
  localparam int DL_HDLC = 0;
  // ************************************************************
  // framing constants
  // ************************************************************
  localparam logic [7:0] BITS_PER_FRAME = 8'hc1;
  localparam logic [4:0] SF_FRAMES = 5'h0c;
  localparam logic [4:0] ESF_FRAMES = 5'h18;
  localparam logic [11:0] SF_FAS = 12'h8dc;
  localparam logic [5:0] ESF_FAS = 6'h0b;
  localparam logic [5:0] CRC_POLY = 6'h03;
  localparam logic [15:0] IDLE_T1 = 16'hffff;
  localparam logic [15:0] IDLE_J1 = 16'hff7e;
  localparam logic [15:0] YEL_T1 = 16'hff00;
  localparam logic [15:0] YEL_J1 = 16'hffff;
  // indirect access latency
  localparam int CLK_PERIOD_NS = 8;
  localparam int BUSY_TIME_NS = 16;
  localparam logic [1:0] BUSY_CYC = 2'((BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic valid;
    logic mfStart;
    logic data;
    logic sig;
    logic redAlarm;
  } tsf_line_in_t;
  typedef struct packed {
    logic valid;
    logic mfStart;
    logic data;
    logic sig;
  } tsf_line_out_t;
  typedef struct packed {
    logic [2:0] valid;
    logic [2:0] bits;
  } tsf_dl_src_t;
endpackage
`default_nettype wire

// ---- tsf_tx_framer.sv ----
// Contract
// - ESF only: select AB-only or full ABCD valid signaling nibble
// - snapshot latches first frame signaling and repeats it for the multiframe
// - global conditioning replaces all ABCD; otherwise per-channel enable decides
// - indirect access by 7-bit address, read/write select, 8-bit data, busy
// - SF alignment 100011011100 (T1) or 10001101110X (J1) on F-bits
// - J1 SF frame 12 F-bit is zero without yellow alarm
// - SF terminal invert flips one odd F-bit, signaling invert one even
// - mimic copies each F-bit into the following bit
// - yellow from manual bit, or auto-enable with received red alarm
// - SF yellow: T1 zeros channel bit 2, J1 sets F-bit 12
// - ESF alignment 001011 on frames 4n
// - ESF signaling invert flips exactly one alignment bit
// - ESF inserts previous multiframe CRC-6 in frames 2,6,...,22
// - ESF CRC invert flips one whole 6-bit CRC pattern
// - data link priority: yellow, BOC, report, HDLC, idle; bypass blocks last four
// - data link idle FFFF for T1, FF7E for J1
// - ESF yellow on data link is FF00 for T1, FFFF for J1
//
// Added by the designer: the strobed register port.
`default_nettype none
module tsf_link
  import tsf_pkg::*;
(
  input wire logic clk, // transmit clock
  input wire logic rst, // synchronous reset
  input wire logic [7:0] regOff, // register offset
  input wire logic [7:0] regWdata, // write data
  input wire logic regWr, // write strobe, link selected
  input wire logic regRd, // read strobe, link selected
  output logic [7:0] regRdata, // read data, zero unless read
  input wire tsf_line_in_t lin, // backplane bit stream
  output tsf_line_out_t lout, // stream toward line encoder
  input wire tsf_dl_src_t dlSrc, // data-link sources
  output logic [2:0] dlTake // source bit consumed
);
  typedef struct packed {
    logic [7:0] testCfg;
    logic [7:0] accCtrl;
    logic [7:0] accData;
    logic [7:0] payCfg;
    logic [7:0] payEn;
    logic [7:0] fgenMode;
    logic [7:0] errIns;
    logic busy;
    logic [1:0] busyCnt;
    logic [127:0][7:0] ind;
    logic [23:0][3:0] snap;
    logic [7:0] bitCnt;
    logic [4:0] frameCnt;
    logic [5:0] crc;
    logic [5:0] crcPrev;
    logic crcInvAct;
    logic [3:0] dlCnt;
    logic lastF;
    logic [1:0] abHold;
    tsf_line_out_t out;
    logic [7:0] rdata;
  } tsf_link_state_t;

  tsf_link_state_t s;
  tsf_link_state_t n;
  logic mfBegin;
  logic [7:0] pBit;
  logic [4:0] pFrm;
  logic [4:0] fNum;
  logic [4:0] chIdx;
  logic [2:0] bIdx;
  logic [1:0] nibK;
  logic isF;
  logic esf;
  logic j1;
  logic framing_disable;
  logic yellow;
  logic expSf;
  logic d;
  logic v;
  logic crcIn;
  logic [5:0] crcBase;
  logic [7:0] strkCode;
  logic [15:0] yelPat;
  logic [15:0] idlePat;

  assign lout = s.out;
  assign regRdata = s.rdata;

  // ************************************************************
  // next-state logic
  // ************************************************************
  always_comb
  begin
    n = s;
    dlTake = 3'h0;
    esf = s.fgenMode[FM_ESF];
    j1 = s.fgenMode[FM_J1];
    framing_disable = s.fgenMode[FM_FRAMING_DISABLE];
    yellow = s.fgenMode[FM_MANYEL] || (s.fgenMode[FM_AUTOYEL] && lin.redAlarm);
    yelPat = j1 ? YEL_J1 : YEL_T1;
    idlePat = j1 ? IDLE_J1 : IDLE_T1;
    mfBegin = lin.valid && lin.mfStart;
    pBit = mfBegin ? 8'h00 : s.bitCnt;
    pFrm = mfBegin ? 5'h00 : s.frameCnt;
    fNum = 5'(pFrm + 5'h01);
    isF = (pBit == 8'h00);
    chIdx = 5'((pBit - 8'h01) >> 3);
    bIdx = 3'(pBit - 8'h01);
    nibK = bIdx[1:0];
    expSf = SF_FAS[4'(4'hb - pFrm[3:0])];
    strkCode = s.ind[7'(IND_STRK_BASE + {2'h0, chIdx})];
    d = lin.data;
    v = lin.sig;
    crcIn = 1'b0;
    crcBase = 6'h00;
    n.out.valid = 1'b0;
    if (lin.valid)
    begin
      // position counters; a new multiframe marker always realigns
      if (pBit == BITS_PER_FRAME - 8'h01)
      begin
        n.bitCnt = 8'h00;
        n.frameCnt = (pFrm == (esf ? ESF_FRAMES : SF_FRAMES) - 5'h01) ? 5'h00 : fNum;
      end
      else
      begin
        n.bitCnt = 8'(pBit + 8'h01);
        n.frameCnt = pFrm;
      end
      // framing bit generation
      if (isF && !framing_disable)
      begin
        if (!esf)
        begin
          d = expSf;
          if (j1 && pFrm == SF_FRAMES - 5'h01)
            d = yellow;
          if (!pFrm[0] && s.errIns[EI_FT])
          begin
            d = !d;
            n.errIns[EI_FT] = 1'b0;
          end
          else if (pFrm[0] && s.errIns[EI_FS])
          begin
            d = !d;
            n.errIns[EI_FS] = 1'b0;
          end
        end
        else if (fNum[1:0] == 2'h0)
        begin
          d = ESF_FAS[3'(3'h6 - fNum[4:2])];
          if (s.errIns[EI_FS])
          begin
            d = !d;
            n.errIns[EI_FS] = 1'b0;
          end
        end
        else if (fNum[1:0] == 2'h2)
        begin
          if (!s.fgenMode[FM_CRC_INSERT_BYPASS])
            d = s.crcPrev[3'(3'h5 - fNum[4:2])];
          if (pFrm == 5'h01)
          begin
            n.crcInvAct = s.errIns[EI_CRC];
            n.errIns[EI_CRC] = 1'b0;
            d = d ^ s.errIns[EI_CRC];
          end
          else
            d = d ^ s.crcInvAct;
        end
        else
        begin
          // data-link bit, sourced by fixed priority
          if (yellow)
            d = yelPat[4'(4'hf - s.dlCnt)];
          else if (!s.fgenMode[FM_DLBYP])
          begin
            if (dlSrc.valid[DL_BOC])
            begin
              d = dlSrc.bits[DL_BOC];
              dlTake[DL_BOC] = 1'b1;
            end
            else if (dlSrc.valid[DL_PRM])
            begin
              d = dlSrc.bits[DL_PRM];
              dlTake[DL_PRM] = 1'b1;
            end
            else if (dlSrc.valid[DL_HDLC])
            begin
              d = dlSrc.bits[DL_HDLC];
              dlTake[DL_HDLC] = 1'b1;
            end
            else
              d = idlePat[4'(4'hf - s.dlCnt)];
          end
          n.dlCnt = 4'(s.dlCnt + 4'h1);
        end
      end
      // with framing disabled the F, CRC and data-link bits stay as received
      if (isF)
        n.lastF = d;
      if (pBit == 8'h01 && s.fgenMode[FM_COPYF] && !framing_disable)
        d = s.lastF;
      if (!isF && !esf && !j1 && yellow && bIdx == 3'h1)
        d = 1'b0;
      // CRC-6 over the outgoing multiframe, F-bits counted as ones
      crcBase = (isF && pFrm == 5'h00) ? 6'h00 : s.crc;
      if (isF && pFrm == 5'h00)
        n.crcPrev = s.crc;
      crcIn = isF ? 1'b1 : d;
      n.crc = {crcBase[4:0], 1'b0} ^ ((crcIn ^ crcBase[5]) ? CRC_POLY : 6'h00);
      // signaling nibble processing, only with the master enable set
      if (s.payEn[PEN_MASTER] && !isF && bIdx[2])
      begin
        if (s.payCfg[PCF_FREEZE])
        begin
          if (pFrm == 5'h00)
            n.snap[chIdx][nibK] = lin.sig;
          else
            v = s.snap[chIdx][nibK];
        end
        if (s.payCfg[PCF_GLOBAL] || strkCode[STRK_EN])
          v = strkCode[2'(2'h3 - nibK)];
        // AB-only: C and D are don't care and repeat A and B
        if (s.payEn[PEN_NIBSEL] && esf)
        begin
          if (!nibK[1])
            n.abHold[nibK[0]] = v;
          else
            v = s.abHold[nibK[0]];
        end
      end
      n.out.valid = 1'b1;
      n.out.mfStart = isF && pFrm == 5'h00;
      n.out.data = d;
      n.out.sig = v;
    end
    // indirect access completes after the busy time
    if (s.busy)
    begin
      n.busyCnt = 2'(s.busyCnt - 2'h1);
      if (s.busyCnt == 2'h1)
      begin
        n.busy = 1'b0;
        if (s.accCtrl[CTRL_RNW])
          n.accData = s.ind[s.accCtrl[6:0]];
        else
          n.ind[s.accCtrl[6:0]] = s.accData;
      end
    end
    // ************************************************************
    // register bus: writes come after the stream logic so a set wins
    // ************************************************************
    if (regWr)
    begin
      if (regOff == OFF_TEST_CFG)
        n.testCfg = regWdata;
      else if (regOff == OFF_ACC_CTRL && !s.busy)
      begin
        n.accCtrl = regWdata;
        n.busy = 1'b1;
        n.busyCnt = BUSY_CYC;
      end
      else if (regOff == OFF_ACC_DATA && !s.busy)
        n.accData = regWdata;
      else if (regOff == OFF_PAY_CFG)
        n.payCfg = regWdata;
      else if (regOff == OFF_PAY_EN)
        n.payEn = regWdata;
      else if (regOff == OFF_FGEN_MODE)
        n.fgenMode = regWdata;
      else if (regOff == OFF_ERR_INS)
        n.errIns = n.errIns | regWdata;
    end
    n.rdata = 8'h00;
    if (regRd)
    begin
      if (regOff == OFF_TEST_CFG)
        n.rdata = s.testCfg;
      else if (regOff == OFF_ACC_STAT)
        n.rdata = {7'h00, s.busy};
      else if (regOff == OFF_ACC_CTRL)
        n.rdata = s.accCtrl;
      else if (regOff == OFF_ACC_DATA)
        n.rdata = s.accData;
      else if (regOff == OFF_PAY_CFG)
        n.rdata = s.payCfg;
      else if (regOff == OFF_PAY_EN)
        n.rdata = s.payEn;
      else if (regOff == OFF_FGEN_MODE)
        n.rdata = s.fgenMode;
      else if (regOff == OFF_ERR_INS)
        n.rdata = s.errIns;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      s <= '0;
    else
      s <= n;
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence fbitSlot;
    lin.valid && isF && !framing_disable;
  endsequence
  sequence accStart;
    regWr && regOff == OFF_ACC_CTRL && !s.busy;
  endsequence

  a_sf_align_bit: assert property (
    fbitSlot and (!esf && !(j1 && pFrm == 5'h0b) && s.errIns[1:0] == 2'h0)
    |=> lout.data == $past(expSf))
    else $error("sf alignment bit wrong");
  a_j1_frame12: assert property (
    fbitSlot and (!esf && j1 && pFrm == 5'h0b && !yellow && s.errIns[1:0] == 2'h0)
    |=> !lout.data)
    else $error("j1 frame 12 f-bit not zero");
  a_t1_yellow_bit: assert property (
    lin.valid && !isF && !esf && !j1 && yellow && bIdx == 3'h1 |=> lout.valid && !lout.data)
    else $error("t1 yellow bit 2 not forced low");
  a_framing_disable_pass_f: assert property (
    lin.valid && isF && framing_disable |=> lout.data == $past(lin.data))
    else $error("f-bit altered while framing disabled");
  a_mimic_copy: assert property (
    fbitSlot ##1 (lin.valid && pBit == 8'h01 && s.fgenMode[FM_COPYF] && !framing_disable)
    |=> lout.data == $past(lout.data, 1))
    else $error("mimic bit differs from f-bit");
  a_busy_window: assert property (
    accStart |=> s.busy [*2] ##1 !s.busy)
    else $error("busy window length wrong");
  a_global_cond: assert property (
    lin.valid && !isF && bIdx[2] && s.payEn[PEN_MASTER] && s.payCfg[PCF_GLOBAL]
    && !(s.payEn[PEN_NIBSEL] && esf)
    |=> lout.sig == $past(strkCode[2'(2'h3 - nibK)]))
    else $error("global conditioning code not sent");
  a_esf_align_bit: assert property (
    fbitSlot and (esf && fNum[1:0] == 2'h0 && !s.errIns[EI_FS])
    |=> lout.data == $past(ESF_FAS[3'(3'h6 - fNum[4:2])]))
    else $error("esf alignment bit wrong");
  a_dl_idle_code: assert property (
    fbitSlot and (esf && fNum[0] && !yellow && !s.fgenMode[FM_DLBYP] && dlSrc.valid == 3'h0)
    |=> lout.data == $past(idlePat[4'(4'hf - s.dlCnt)]))
    else $error("idle code bit wrong");
endmodule

module tsf_tx_framer
  import tsf_pkg::*;
#(
  parameter int NUM_LINKS = 8
)
(
  input wire logic clk, // transmit clock
  input wire logic rst, // synchronous reset
  input wire logic [REG_ADDR_W-1:0] regAddr, // link in [10:8], offset in [7:0]
  input wire logic [7:0] regWdata, // write data
  input wire logic regWr, // write strobe
  input wire logic regRd, // read strobe
  output logic [7:0] regRdata, // read data, cycle after strobe
  input wire tsf_line_in_t [NUM_LINKS-1:0] lineIn, // per-link input stream
  output tsf_line_out_t [NUM_LINKS-1:0] lineOut, // per-link output stream
  input wire tsf_dl_src_t [NUM_LINKS-1:0] dlSrc, // per-link data-link sources
  output logic [NUM_LINKS-1:0][2:0] dlTake // per-link source consumed
);
  logic [NUM_LINKS-1:0][7:0] linkRdata;

  function automatic logic linkHit(input logic [REG_ADDR_W-1:0] a, input int idx);
    linkHit = (int'(a[REG_ADDR_W-1:LINK_ADDR_LSB]) == idx);
  endfunction

  // each link is a full copy selected by the upper address bits
  for (genvar g = 0; g < NUM_LINKS; g++)
  begin : gLink
    tsf_link uLink (
      .clk(clk),
      .rst(rst),
      .regOff(regAddr[LINK_ADDR_LSB-1:0]),
      .regWdata(regWdata),
      .regWr(regWr && linkHit(regAddr, g)),
      .regRd(regRd && linkHit(regAddr, g)),
      .regRdata(linkRdata[g]),
      .lin(lineIn[g]),
      .lout(lineOut[g]),
      .dlSrc(dlSrc[g]),
      .dlTake(dlTake[g])
    );
  end

  // unselected links return zero, so an OR merges them
  always_comb
  begin
    regRdata = 8'h00;
    for (int i = 0; i < NUM_LINKS; i++)
      regRdata = regRdata | linkRdata[i];
  end
endmodule
`default_nettype wire

// ---- tsf_bp_model.sv ----
`default_nettype none
// ************************************************************
// backplane stream source for one link
// ************************************************************
module tsf_bp_model
  import tsf_pkg::*;
(
  input wire logic clk, // transmit clock
  input wire logic rst, // synchronous reset
  input wire logic run, // stream enable
  input wire logic esf, // 24-frame multiframe when high
  input wire logic red, // received red alarm level
  output tsf_line_in_t lin // stream into the framer
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial lin = '0;
  always @(posedge clk)
  begin
    if (rst || !run)
    begin
      cnt <= 0;
      lin.valid <= 1'b0;
      lin.mfStart <= 1'b0;
      // stopped line toggles so no stale bit can pass for data
      lin.data <= ~lin.data;
      lin.sig <= ~lin.sig;
    end
    else
    begin
      lin.valid <= 1'b1;
      lin.mfStart <= (cnt == 0);
      lin.data <= 1'($urandom);
      lin.sig <= 1'($urandom);
      cnt <= (cnt == (esf ? 24 : 12) * 193 - 1) ? 0 : cnt + 1;
    end
    lin.redAlarm <= red;
  end
endmodule
`default_nettype wire

// ---- t1_tx_signaling_and_framing_tb.sv ----
`default_nettype none
module t1_tx_signaling_and_framing_tb
  import tsf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NL = 8;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [REG_ADDR_W-1:0] regAddr = '0;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdata;
  tsf_line_in_t lin;
  tsf_line_in_t inPrev;
  tsf_line_in_t [NL-1:0] lineIn;
  tsf_line_out_t [NL-1:0] lineOut;
  tsf_dl_src_t dls = '0;
  tsf_dl_src_t [NL-1:0] dlSrc;
  logic [NL-1:0][2:0] dlTake;
  logic run = 1'b0;
  logic red = 1'b0;
  logic esf = 1'b0;
  logic j1, framing_disable, mim, dlby, yelOn, hdlc, hb, pm, strk, glob, crcby, frz, absel;
  logic sync = 1'b0;
  logic [3:0] codeT [1:24];
  logic [3:0] snapT [1:24];
  logic [1:0] abT = 2'h0;
  logic [1:0] eD, eS;
  logic ftPend = 1'b0;
  logic fsPend = 1'b0;
  logic crcPend = 1'b0;
  logic crcNow = 1'b0;
  logic [5:0] crcRun = 6'h00;
  logic [5:0] crcLast = 6'h00;
  int fr, pos, nTake, nBoc, nDl0;
  int n_fail = 0;
  int n_checks = 0;
  assign lineIn = {NL{lin}};
  assign dlSrc = {NL{dls}};
  always #4 clk = ~clk;
  tsf_tx_framer #(.NUM_LINKS(NL)) tsf_tx_framer_inst (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .lineIn(lineIn), .lineOut(lineOut),
    .dlSrc(dlSrc), .dlTake(dlTake));
  tsf_bp_model tsf_bp_model_inst (
    .clk(clk), .rst(rst), .run(run), .esf(esf), .red(red), .lin(lin));
  // ************************************************************
  // checking helpers
  // ************************************************************
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic [1:0] e, input string m);
    if (e[1])
    begin
      n_checks++;
      if (got !== e[0])
      begin
        n_fail++;
        $display("BAD %0t %s frame %0d bit %0d", $time, m, fr, pos);
      end
    end
  endtask
  // expected F-bit as {care, value}
  function automatic logic [1:0] exp_f(int f, logic d);
    logic [11:0] sf;
    logic [5:0] ef;
    sf = 12'h8dc;
    ef = 6'h0b;
    if (framing_disable) return {1'b1, d};
    if (!esf) return {1'b1, (j1 && f == 12) ? yelOn : sf[12 - f]};
    if (f % 4 == 0) return {1'b1, ef[6 - f / 4]};
    if (f % 2 == 0) return {1'b1, crcby ? d : crcLast[5 - (f - 2) / 4]};
    // the free-running yellow pattern is counted elsewhere
    if (yelOn) return 2'b00;
    if (dlby) return {1'b1, d};
    return {1'b1, hdlc ? hb : 1'b1};
  endfunction
  function automatic logic [1:0] exp_d(int f, int p, logic d);
    if (p == 0 || (p == 1 && mim && !framing_disable)) return exp_f(f, d);
    if (!esf && !j1 && yelOn && (p - 1) % 8 == 1) return 2'b10;
    return {1'b1, d};
  endfunction
  function automatic logic [1:0] exp_s(int p, logic d);
    int k;
    int ch;
    logic v;
    k = (p - 1) % 8;
    ch = (p - 1) / 8 + 1;
    if (p == 0) return 2'b00;
    if (!pm || k < 4) return {1'b1, d};
    v = (frz && fr != 1) ? snapT[ch][7 - k] : d;
    if (glob || (strk && ch % 2 == 1)) v = codeT[ch][7 - k];
    if (absel && esf && k >= 6) v = abT[k % 2];
    return {1'b1, v};
  endfunction
  function automatic logic [5:0] crc_step(logic [5:0] c, logic b);
    return {c[4:0], 1'b0} ^ ((b ^ c[5]) ? CRC_POLY : 6'h00);
  endfunction
  always @(posedge clk)
  begin
    if (lineOut[0].valid)
    begin
      if (lineOut[0].mfStart)
      begin
        fr = 1;
        pos = 0;
        sync = 1'b1;
        crcLast = crcRun;
        crcRun = 6'h00;
      end
      else if (pos == 192)
      begin
        pos = 0;
        fr = fr + 1;
      end
      else
        pos = pos + 1;
      if (sync)
      begin
        eD = exp_d(fr, pos, inPrev.data);
        if (pos == 0 && !framing_disable)
        begin
          if (!esf && ftPend && fr % 2 == 1)
          begin
            eD[0] = !eD[0];
            ftPend = 1'b0;
          end
          else if (fsPend && fr % (esf ? 4 : 2) == 0)
          begin
            eD[0] = !eD[0];
            fsPend = 1'b0;
          end
          else if (esf && fr % 4 == 2)
          begin
            if (fr == 2)
            begin
              crcNow = crcPend;
              crcPend = 1'b0;
            end
            eD[0] = eD[0] ^ crcNow;
          end
        end
        chkb(lineOut[0].data, eD, "data");
        eS = exp_s(pos, inPrev.sig);
        chkb(lineOut[0].sig, eS, "sig");
        if (esf && pos == 0 && fr % 2 == 1 && lineOut[0].data === 1'b0) nDl0++;
        if (pos != 0 && (pos - 1) % 8 >= 4)
        begin
          if (fr == 1) snapT[(pos - 1) / 8 + 1][7 - (pos - 1) % 8] = inPrev.sig;
          if ((pos - 1) % 8 < 6) abT[(pos - 1) % 2] = eS[0];
        end
        crcRun = crc_step(crcRun, (pos == 0) ? 1'b1 : lineOut[0].data);
      end
    end
    // error-insert requests seen on the bus arm one inversion each
    if (regWr && regAddr == {3'h0, OFF_ERR_INS})
    begin
      ftPend = ftPend | regWdata[EI_FT];
      fsPend = fsPend | regWdata[EI_FS];
      crcPend = crcPend | regWdata[EI_CRC];
    end
    if (dlTake[0] != 3'h0) nTake++;
    if (dlTake[0] == 3'h4) nBoc++;
    inPrev = lineIn[0];
  end
  // ************************************************************
  // bus and stream tasks
  // ************************************************************
  task automatic wr(input logic [2:0] ln, input logic [7:0] off, input logic [7:0] d);
    @(posedge clk);
    regAddr <= {ln, off};
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] ln, input logic [7:0] off, output logic [7:0] q);
    @(posedge clk);
    regAddr <= {ln, off};
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 q = regRdata;
  endtask
  task automatic poll();
    logic [7:0] q;
    q = 8'h01;
    for (int i = 0; i < 8 && q[0] !== 1'b0; i++) rd(0, OFF_ACC_STAT, q);
    chk8(q, 8'h00, "busy stuck");
    if (q !== 8'h00) give_verdict();
  endtask
  task automatic cfg(input logic [7:0] m);
    wr(0, OFF_FGEN_MODE, m);
    {esf, j1, framing_disable, crcby, dlby, mim} = {m[0], m[1], m[2], m[3], m[4], m[5]};
    yelOn = m[6] | (m[7] & red);
  endtask
  task automatic stream(input int n);
    nTake = 0;
    nBoc = 0;
    nDl0 = 0;
    run <= 1'b1;
    repeat (n * (esf ? 24 : 12) * 193) @(posedge clk);
    run <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  initial
  begin
    logic [7:0] q, v;
    logic [7:0] offs [6];
    offs = '{OFF_PAY_EN, OFF_PAY_CFG, OFF_ACC_STAT, OFF_ACC_DATA, OFF_FGEN_MODE, 8'h00};
    {j1, framing_disable, mim, dlby, yelOn, hdlc, hb, pm, strk, glob, crcby, frz, absel} = '0;
    void'($urandom(34747));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    foreach (offs[i])
    begin
      rd(0, offs[i], q);
      chk8(q, 8'h00, "reset value");
    end
    v = 8'($urandom);
    wr(3, OFF_PAY_EN, v);
    rd(3, OFF_PAY_EN, q);
    chk8(q, v, "link 3 enable");
    rd(0, OFF_PAY_EN, q);
    chk8(q, 8'h00, "link 0 untouched");
    wr(0, OFF_ACC_STAT, 8'hff);
    wr(0, 8'h00, v);
    rd(0, OFF_ACC_STAT, q);
    chk8(q, 8'h00, "status read-only");
    rd(0, 8'h00, q);
    chk8(q, 8'h00, "unmapped");
    // indirect write, then read back with a data write refused while busy
    wr(0, OFF_ACC_DATA, v);
    wr(0, OFF_ACC_CTRL, 8'h45);
    poll();
    @(posedge clk);
    regAddr <= {3'h0, OFF_ACC_CTRL};
    regWdata <= 8'hc5;
    regWr <= 1'b1;
    @(posedge clk);
    regAddr <= {3'h0, OFF_ACC_DATA};
    regWdata <= ~v;
    @(posedge clk);
    regWr <= 1'b0;
    poll();
    rd(0, OFF_ACC_DATA, q);
    chk8(q, v, "indirect readback");
    // super-frame: mimic, auto yellow, J1 frame 12
    cfg(8'h20);
    stream(2);
    red <= 1'b1;
    cfg(8'h80);
    stream(1);
    red <= 1'b0;
    cfg(8'h02);
    wr(0, OFF_ERR_INS, 8'h03);
    stream(1);
    cfg(8'h42);
    stream(1);
    // extended super-frame data link sources
    cfg(8'h01);
    wr(0, OFF_ERR_INS, 8'h06);
    stream(1);
    chk8(8'(nTake), 8'h00, "idle takes");
    hb = 1'($urandom);
    hdlc = 1'b1;
    dls <= '{valid: 3'h1, bits: {3{hb}}};
    stream(1);
    chk8(8'(nTake), 8'h0c, "hdlc takes");
    dls <= '{valid: 3'h5, bits: {3{hb}}};
    stream(1);
    chk8(8'(nBoc), 8'h0c, "boc priority");
    cfg(8'h11);
    stream(1);
    chk8(8'(nTake), 8'h00, "bypass takes");
    cfg(8'h41);
    stream(4);
    chk8(8'(nTake), 8'h00, "yellow takes");
    chk8(8'(nDl0), 8'h18, "yellow zeros");
    hdlc = 1'b0;
    dls <= '0;
    cfg(8'h05);
    stream(1);
    // per-channel then global signaling conditioning
    for (int ch = 1; ch <= 24; ch++)
    begin
      codeT[ch] = 4'($urandom);
      wr(0, OFF_ACC_DATA, {3'h0, 1'(ch % 2), codeT[ch]});
      wr(0, OFF_ACC_CTRL, {1'b0, 7'(IND_STRK_BASE + 7'(ch - 1))});
      poll();
    end
    wr(0, OFF_PAY_EN, 8'h01);
    pm = 1'b1;
    strk = 1'b1;
    cfg(8'h00);
    stream(1);
    wr(0, OFF_PAY_CFG, 8'h02);
    glob = 1'b1;
    stream(1);
    // snapshot and AB-only selection with per-channel conditioning, CRC bypassed
    wr(0, OFF_PAY_CFG, 8'h01);
    wr(0, OFF_PAY_EN, 8'h03);
    {glob, frz, absel} = 3'b011;
    cfg(8'h09);
    stream(1);
    give_verdict();
  end
endmodule
`default_nettype wire
